// File: logic/pbw_power_status.sv
// Purpose: Power button and alarm status, wake control and the access
//          arbitration register of the soft power block.
// Assumes: All inputs synchronous to clk_sys; reset pulses are one cycle
//          or longer levels; alarm is a one-cycle event.
// Notes:   The supply-on pin is open drain: enable high pulls it low.
`timescale 1ns/100ps
`include "pbw_defs.svh"

module pbw_power_status #(
	parameter int unsigned HOLD_CYCLES = `PBW_HOLD_CYCLES
) (
	// Clock and reset
	input  wire logic                 clk_sys,
	input  wire logic                 rst,
	input  wire pbw_pkg::pbw_resets_t resets,
	// Register access
	input  wire pbw_pkg::pbw_reg_req_t regReq,
	output logic [7:0]                regRdData,
	// Enables held in the enable and control registers
	input  wire logic                 buttonEventEnable,
	input  wire logic                 alarmEventEnable,
	input  wire logic                 alarmRememberEnable,
	input  wire logic                 wakeStatusEnable,
	input  wire logic                 sleepRequest,
	// Event sources
	input  wire logic                 buttonInputN,
	input  wire logic                 alarmEvent,
	input  wire logic                 standbyPresent,
	input  wire logic                 arbGrant,
	// Pins
	output logic                      pmEventOutN,
	output logic                      supplyOnOut,
	output logic                      supplyOnOe
);

	logic                buttonPressFlag_reg;
	logic                alarmFlag_reg;
	logic                buttonOverrideFlag_reg;
	logic                wakeFlag_reg;
	logic                accessRequest_reg;
	logic                accessGrant_reg;
	logic                sleptBySoftware_reg;
	logic                buttonHeldPrev_reg;
	pbw_pkg::pbw_supply_t supply_reg;
	pbw_pkg::pbw_supply_t supply_next;

	logic buttonHeld;
	logic holdExpired;
	logic writeStatusTwo;
	logic writeArb;
	logic alarmWake;
	logic rememberWake;
	logic buttonWake;
	logic wakeNow;

	assign buttonHeld     = !buttonInputN;
	assign writeStatusTwo = regReq.write
		&& (regReq.addr == `PBW_OFS_STATUS_TWO);
	assign writeArb       = regReq.write && (regReq.addr == `PBW_OFS_ARB);

	pbw_hold_timer #(
		.HOLD_CYCLES (HOLD_CYCLES)
	) holdTimer (
		.clk_sys     (clk_sys),
		.rst         (rst),
		.buttonHeld  (buttonHeld),
		.holdExpired (holdExpired)
	);

	// Button flag: the override clear beats the set, since the same held
	// level would otherwise keep it set at the moment of override.
	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			buttonPressFlag_reg <= 1'b0;
		end else if (resets.batteryPor || holdExpired) begin
			buttonPressFlag_reg <= 1'b0;
		end else if (buttonHeld) begin
			buttonPressFlag_reg <= 1'b1;
		end else if (writeStatusTwo
				&& regReq.data[`PBW_STS_BUTTON_BIT]) begin
			buttonPressFlag_reg <= 1'b0;
		end
	end

	// Alarms set the flag with or without standby power present.
	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			alarmFlag_reg <= 1'b0;
		end else if (resets.batteryPor) begin
			alarmFlag_reg <= 1'b0;
		end else if (alarmEvent) begin
			alarmFlag_reg <= 1'b1;
		end else if (writeStatusTwo
				&& regReq.data[`PBW_STS_ALARM_BIT]) begin
			alarmFlag_reg <= 1'b0;
		end
	end

	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			buttonOverrideFlag_reg <= 1'b0;
		end else if (resets.batteryPor) begin
			buttonOverrideFlag_reg <= 1'b0;
		end else if (holdExpired) begin
			buttonOverrideFlag_reg <= 1'b1;
		end else if (writeStatusTwo
				&& regReq.data[`PBW_STS_OVERRIDE_BIT]) begin
			buttonOverrideFlag_reg <= 1'b0;
		end
	end

	// A wake needs a fresh press: the hold that forced the override is
	// still on the pin and must not turn the supply straight back on.
	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			buttonHeldPrev_reg <= 1'b0;
		end else begin
			buttonHeldPrev_reg <= buttonHeld;
		end
	end

	// Wake sources; everything but the button waits for override clear.
	assign buttonWake   = buttonHeld && !buttonHeldPrev_reg;
	assign alarmWake    = alarmEvent && alarmEventEnable
		&& !buttonOverrideFlag_reg;
	assign rememberWake = resets.standbyPor && alarmRememberEnable
		&& (alarmFlag_reg || alarmEvent)
		&& !buttonOverrideFlag_reg;
	assign wakeNow      = buttonWake || alarmWake || rememberWake;

	always_comb begin
		supply_next = supply_reg;
		unique case (supply_reg)
			pbw_pkg::SUPPLY_ON: begin
				if (holdExpired || sleepRequest) begin
					supply_next = pbw_pkg::SUPPLY_SOFT_OFF;
				end
			end
			pbw_pkg::SUPPLY_SOFT_OFF: begin
				if (wakeNow) begin
					supply_next = pbw_pkg::SUPPLY_ON;
				end
			end
		endcase
	end

	// Main reset powers up in soft-off; a wake turns the supply on.
	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			supply_reg <= pbw_pkg::SUPPLY_SOFT_OFF;
		end else begin
			supply_reg <= supply_next;
		end
	end

	// Only a software sleep lets the wake status bit record the wake.
	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			sleptBySoftware_reg <= 1'b0;
		end else if (supply_reg == pbw_pkg::SUPPLY_ON) begin
			sleptBySoftware_reg <= sleepRequest && !holdExpired;
		end
	end

	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			wakeFlag_reg <= 1'b0;
		end else if (resets.batteryPor || resets.standbyPor) begin
			wakeFlag_reg <= 1'b0;
		end else if (supply_reg == pbw_pkg::SUPPLY_SOFT_OFF && wakeNow
				&& sleptBySoftware_reg && wakeStatusEnable) begin
			wakeFlag_reg <= 1'b1;
		end else if (writeStatusTwo
				&& regReq.data[`PBW_STS_WAKE_BIT]) begin
			wakeFlag_reg <= 1'b0;
		end
	end

	// Soft reset clears the request but leaves the grant where it is.
	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			accessRequest_reg <= 1'b0;
		end else if (resets.standbyPor || resets.pciReset
				|| resets.softReset) begin
			accessRequest_reg <= 1'b0;
		end else if (writeArb) begin
			accessRequest_reg <= regReq.data[`PBW_ARB_REQ_BIT];
		end
	end

	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			accessGrant_reg <= 1'b1;
		end else if (resets.standbyPor || resets.pciReset) begin
			accessGrant_reg <= 1'b1;
		end else begin
			accessGrant_reg <= arbGrant;
		end
	end

	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			regRdData <= 8'h00;
		end else begin
			regRdData <= 8'h00;
			if (regReq.read) begin
				unique case (regReq.addr)
					`PBW_OFS_ARB: begin
						regRdData <= {6'h00, accessGrant_reg,
							accessRequest_reg};
					end
					`PBW_OFS_STATUS_ONE: begin
						regRdData <= `PBW_STATUS_ONE_VALUE;
					end
					`PBW_OFS_STATUS_TWO: begin
						regRdData <= {wakeFlag_reg, 3'h0,
							buttonOverrideFlag_reg, alarmFlag_reg,
							1'b0, buttonPressFlag_reg};
					end
					default: begin
						regRdData <= 8'h00;
					end
				endcase
			end
		end
	end

	assign pmEventOutN = !((buttonEventEnable && buttonPressFlag_reg)
		|| (alarmEventEnable && alarmFlag_reg));
	assign supplyOnOut = 1'b0;
	assign supplyOnOe  = (supply_reg == pbw_pkg::SUPPLY_ON);

endmodule : pbw_power_status

// File: logic/pbw_defs.svh
// Purpose: Offsets, field positions, reset values and timing counts for the
//          power button and alarm status block.
// Assumes: Included by bare name from the two design files, not from the package.
// Notes:   Definitions only.
`ifndef PBW_DEFS_SVH
`define PBW_DEFS_SVH

`define PBW_OFS_ARB         8'h77
`define PBW_OFS_STATUS_ONE  8'h78
`define PBW_OFS_STATUS_TWO  8'h79

`define PBW_ARB_REQ_BIT     0
`define PBW_ARB_GNT_BIT     1
`define PBW_ARB_RESET       8'h02

`define PBW_STS_BUTTON_BIT   0
`define PBW_STS_ALARM_BIT    2
`define PBW_STS_OVERRIDE_BIT 3
`define PBW_STS_WAKE_BIT     7
`define PBW_STS_RESET        8'h00
`define PBW_STATUS_ONE_VALUE 8'h00

`define PBW_HOLD_SECONDS    4
`define PBW_CLK_HZ          50000000
`define PBW_HOLD_CYCLES     (`PBW_HOLD_SECONDS * `PBW_CLK_HZ)

`endif

// File: logic/pbw_pkg.sv
// Purpose: Types shared by the power button and alarm status block.
// Assumes: Offsets and counts live in pbw_defs.svh.
// Notes:   Nothing here is imported; users write pbw_pkg::name.
package pbw_pkg;

	typedef enum logic [0:0] {
		SUPPLY_ON,
		SUPPLY_SOFT_OFF
	} pbw_supply_t;

	// One register access from the host side.
	typedef struct packed {
		logic       write;
		logic       read;
		logic [7:0] addr;
		logic [7:0] data;
	} pbw_reg_req_t;

	// Reset sources other than the main asynchronous reset.
	typedef struct packed {
		logic batteryPor;
		logic standbyPor;
		logic pciReset;
		logic softReset;
	} pbw_resets_t;

endpackage : pbw_pkg

// File: logic/pbw_hold_timer.sv
// Purpose: Measures how long the power button has been held.
// Assumes: buttonHeld is synchronous to clk_sys.
// Notes:   Fires once per hold; a release restarts the count.
`timescale 1ns/100ps
`include "pbw_defs.svh"

module pbw_hold_timer #(
	parameter int unsigned HOLD_CYCLES = `PBW_HOLD_CYCLES
) (
	// Clock and reset
	input  wire logic clk_sys,
	input  wire logic rst,
	// Button level and result
	input  wire logic buttonHeld,
	output logic      holdExpired
);

	logic [31:0] count_reg;
	logic        fired_reg;

	// Counting past the limit rather than to it keeps "more than" exact.
	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			count_reg <= 32'h0;
		end else if (!buttonHeld) begin
			count_reg <= 32'h0;
		end else if (count_reg <= 32'(HOLD_CYCLES)) begin
			count_reg <= count_reg + 32'h1;
		end
	end

	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			fired_reg <= 1'b0;
		end else if (!buttonHeld) begin
			fired_reg <= 1'b0;
		end else if (holdExpired) begin
			fired_reg <= 1'b1;
		end
	end

	assign holdExpired = buttonHeld && !fired_reg
		&& (count_reg > 32'(HOLD_CYCLES));

endmodule : pbw_hold_timer

// File: verification/pbw_status_properties.sv
// Purpose: Port-level checks of the soft power status block.
// Assumes: Bound to pbw_power_status; HOLD_CYCLES handed on by the bind.
// Notes:   The hold check only bounds an early soft-off, not a late one.
`timescale 1ns/100ps
module pbw_status_properties #(
	parameter int unsigned HOLD_CYCLES = 20
) (
	input wire logic                  clk_sys,
	input wire logic                  rst,
	input wire pbw_pkg::pbw_resets_t  resets,
	input wire pbw_pkg::pbw_reg_req_t regReq,
	input wire logic [7:0]            regRdData,
	input wire logic                  buttonEventEnable,
	input wire logic                  alarmEventEnable,
	input wire logic                  alarmRememberEnable,
	input wire logic                  wakeStatusEnable,
	input wire logic                  sleepRequest,
	input wire logic                  buttonInputN,
	input wire logic                  alarmEvent,
	input wire logic                  standbyPresent,
	input wire logic                  arbGrant,
	input wire logic                  pmEventOutN,
	input wire logic                  supplyOnOut,
	input wire logic                  supplyOnOe
);
	logic [31:0] holdCnt;

	// Any release restarts the run, so a split hold never reaches the limit.
	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst)
			holdCnt <= 32'h0;
		else
			holdCnt <= buttonInputN ? 32'h0 : holdCnt + 32'h1;
	end

	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (rst);

	sequence rdArb;
		regReq.read && regReq.addr == 8'h77 && resets == 4'h0;
	endsequence

	chk_stsone_zero: assert property (
		regReq.read && regReq.addr == 8'h78 |=> regRdData == 8'h00)
		else $error("status one read not zero");
	chk_grant_copy: assert property (
		rdArb ##0 ($past(resets) == 4'h0 && arbGrant == $past(arbGrant))
		|=> regRdData[7:1] == {6'h00, $past(arbGrant)})
		else $error("grant bit not copied");
	chk_event_gate: assert property (
		!buttonEventEnable && !alarmEventEnable |-> pmEventOutN)
		else $error("event with no enable");
	chk_button_wake: assert property (
		$fell(buttonInputN) && !supplyOnOe && !resets.batteryPor
		|=> supplyOnOe)
		else $error("button did not wake");
	chk_alarm_gate: assert property (
		!supplyOnOe && buttonInputN && !alarmEventEnable
		&& !resets.standbyPor && !sleepRequest |=> !supplyOnOe)
		else $error("wake with no enabled source");
	chk_hold_min: assert property (
		$fell(supplyOnOe) && !$past(sleepRequest)
		&& !$past(resets.batteryPor) |-> holdCnt >= HOLD_CYCLES)
		else $error("soft-off before hold limit");
	chk_batt_clear: assert property (
		resets.batteryPor && buttonInputN && !alarmEvent |=> pmEventOutN)
		else $error("flags kept over battery reset");
	chk_idle_read: assert property (
		!regReq.read |=> regRdData == 8'h00)
		else $error("read data without read");
endmodule : pbw_status_properties

// File: verification/pbw_supply_model.sv
// Purpose: Power supply seen through the open-drain supply-on pin.
// Assumes: The pin has a pull-up; a low level turns the supply on.
// Notes:   Behavioural only.
`timescale 1ns/100ps
module pbw_supply_model (
	// Pin from the block
	input  wire logic supplyOnOut,
	input  wire logic supplyOnOe,
	// Resolved pin and supply state
	output logic      supplyOnN,
	output logic      running
);
	assign supplyOnN = supplyOnOe ? supplyOnOut : 1'b1;
	assign running   = (supplyOnN === 1'b0);
endmodule : pbw_supply_model

// File: verification/tb.sv
// Purpose: Register and pin tests of the soft power status block.
// Assumes: Hold limit shortened to HOLD cycles.
// Notes:   Inputs change on the falling edge only.
`timescale 1ns/100ps
module tb;
	localparam int unsigned HOLD = 20;
	logic                  clk_sys = 1'b0;
	logic                  rst = 1'b1;
	pbw_pkg::pbw_resets_t  resets = '0;
	pbw_pkg::pbw_reg_req_t regReq = '0;
	logic [7:0]            regRdData;
	logic btnEn = 1'b0, alEn = 1'b0, remEn = 1'b0, sleepRequest = 1'b0;
	logic buttonInputN = 1'b1, alarmEvent = 1'b0, arbGrant = 1'b1;
	logic wakeEn = 1'b0;
	logic pmEventOutN, supplyOnOut, supplyOnOe, supplyOnN, running;
	int   n_errors = 0;
	int   num_checks = 0;

	always #10 clk_sys = ~clk_sys;

	pbw_power_status #(.HOLD_CYCLES(HOLD)) pbw_power_status_i (
		.clk_sys(clk_sys), .rst(rst), .resets(resets), .regReq(regReq),
		.regRdData(regRdData), .buttonEventEnable(btnEn),
		.alarmEventEnable(alEn), .alarmRememberEnable(remEn),
		.wakeStatusEnable(wakeEn), .sleepRequest(sleepRequest),
		.buttonInputN(buttonInputN), .alarmEvent(alarmEvent),
		.standbyPresent(1'b1), .arbGrant(arbGrant),
		.pmEventOutN(pmEventOutN), .supplyOnOut(supplyOnOut),
		.supplyOnOe(supplyOnOe));
	pbw_supply_model pbw_supply_model_i (.supplyOnOut(supplyOnOut),
		.supplyOnOe(supplyOnOe), .supplyOnN(supplyOnN), .running(running));

	task automatic cyc(input int n);
		repeat (n) @(negedge clk_sys);
	endtask : cyc
	task automatic cmp(input logic [7:0] got, exp, input string what);
		num_checks++;
		if (got !== exp) begin
			n_errors++;
			$display("[FAIL] %0t %s got %h exp %h", $time, what, got, exp);
		end
	endtask : cmp
	task automatic wr(input logic [7:0] a, d);
		regReq = '{1'b1, 1'b0, a, d};
		cyc(1);
		regReq = '0;
		cyc(1);
	endtask : wr
	task automatic rd(input logic [7:0] a, exp, input string what);
		regReq = '{1'b0, 1'b1, a, 8'h00};
		cyc(1);
		regReq = '0;
		cmp(regRdData, exp, what);
		cyc(1);
	endtask : rd
	task automatic press(input int n);
		buttonInputN = 1'b0;
		cyc(n);
		buttonInputN = 1'b1;
		cyc(2);
	endtask : press
	task automatic alarm;
		alarmEvent = 1'b1;
		cyc(1);
		alarmEvent = 1'b0;
		cyc(2);
	endtask : alarm
	task automatic final_report;
		$display("checks %0d errors %0d", num_checks, n_errors);
		if (n_errors == 0 && num_checks > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask : final_report

	initial begin
		#100000;
		n_errors++;
		$display("[FAIL] %0t watchdog", $time);
		final_report();
	end

	initial begin
		cyc(6);
		rst = 1'b0;
		cyc(1);
		rd(8'h77, 8'h02, "arb reset");
		arbGrant = 1'b0;
		wr(8'h77, 8'hff);
		rd(8'h77, 8'h01, "arb rw");
		arbGrant = 1'b1;
		wr(8'h78, 8'hff);
		rd(8'h78, 8'h00, "sts one");
		rd(8'h79, 8'h00, "sts two reset");
		$display("test regs done");
		btnEn = 1'b1;
		press(3);
		cmp({7'h00, running}, 8'h01, "button wake");
		cmp({7'h00, pmEventOutN}, 8'h00, "button event");
		wr(8'h79, 8'h00);
		rd(8'h79, 8'h01, "button flag");
		wr(8'h79, 8'h01);
		cmp({7'h00, pmEventOutN}, 8'h01, "event gone");
		alarm();
		rd(8'h79, 8'h04, "alarm flag");
		wr(8'h79, 8'h04);
		$display("test flags done");
		press(HOLD - 5);
		press(HOLD - 5);
		cmp({7'h00, running}, 8'h01, "split hold");
		wr(8'h79, 8'h01);
		press(HOLD + 6);
		cmp({7'h00, running}, 8'h00, "override off");
		rd(8'h79, 8'h09, "override flag");
		alEn = 1'b1;
		alarm();
		cmp({7'h00, running}, 8'h00, "override blocks");
		rd(8'h79, 8'h0d, "alarm in override");
		wr(8'h79, 8'h0d);
		alarm();
		cmp({7'h00, running}, 8'h01, "alarm wake");
		cmp({7'h00, pmEventOutN}, 8'h00, "alarm event");
		$display("test override done");
		wakeEn = 1'b1;
		sleepRequest = 1'b1;
		cyc(1);
		sleepRequest = 1'b0;
		cyc(2);
		cmp({7'h00, running}, 8'h00, "first sleep off");
		press(3);
		cmp({7'h00, running}, 8'h01, "press after sleep");
		rd(8'h79, 8'h85, "wake flag set");
		sleepRequest = 1'b1;
		cyc(1);
		sleepRequest = 1'b0;
		alEn = 1'b0;
		remEn = 1'b1;
		cyc(2);
		cmp({7'h00, running}, 8'h00, "sleep off");
		resets.standbyPor = 1'b1;
		cyc(1);
		resets.standbyPor = 1'b0;
		cyc(2);
		cmp({7'h00, running}, 8'h01, "remember wake");
		rd(8'h79, 8'h05, "standby clears bit7");
		rd(8'h77, 8'h02, "standby arb");
		resets.batteryPor = 1'b1;
		cyc(1);
		resets.batteryPor = 1'b0;
		cyc(1);
		rd(8'h79, 8'h00, "battery clear");
		$display("test resets done");
		final_report();
	end
endmodule : tb

bind pbw_power_status pbw_status_properties #(.HOLD_CYCLES(HOLD_CYCLES))
	chk_i (.clk_sys(clk_sys), .rst(rst), .resets(resets), .regReq(regReq),
	.regRdData(regRdData), .buttonEventEnable(buttonEventEnable),
	.alarmEventEnable(alarmEventEnable),
	.alarmRememberEnable(alarmRememberEnable),
	.wakeStatusEnable(wakeStatusEnable), .sleepRequest(sleepRequest),
	.buttonInputN(buttonInputN), .alarmEvent(alarmEvent),
	.standbyPresent(standbyPresent), .arbGrant(arbGrant),
	.pmEventOutN(pmEventOutN), .supplyOnOut(supplyOnOut),
	.supplyOnOe(supplyOnOe));
